// ==== logic/serial_control_port_pkg.sv ====
// Shared constants, types and decode helpers of the serial control port
package serial_control_port_pkg;

  // Host register map
  localparam logic [7:0] DATA_OFFSET      = 8'h00;
  localparam logic [7:0] CONTROL_OFFSET   = 8'h01;
  localparam logic [7:0] CH0_IFACE_OFFSET = 8'h20;
  localparam logic [7:0] CH1_IFACE_OFFSET = 8'h40;

  // Control/status register fields
  localparam int ENABLE0_BIT  = 0;
  localparam int ENABLE1_BIT  = 1;
  localparam int TRANSMIT_BIT = 2;
  localparam int DONE_BIT     = 3;
  localparam int DONE_IE_BIT  = 4;
  localparam int BAUD_LSB     = 5;
  localparam int BAUD_MSB     = 6;
  localparam int CI_BIT       = 7;

  // Serial interface control register fields
  localparam int SERIAL_PORT_ENABLE_BIT_BIT  = 0;
  localparam int SLAVE_BIT = 1;

  // Reset values and the data read while busy
  localparam logic [7:0] DATA_RESET    = 8'h00;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] IFACE_RESET   = 8'h00;
  localparam logic [7:0] BUSY_READ     = 8'h00;

  // Timing
  localparam int         MCLK_PERIOD_NS  = 4;
  localparam logic [3:0] BITS_PER_BURST  = 4'h8;
  localparam int         MAX_TAP_DIVIDE  = 16;
  localparam int         START_LATENCY_MCLK = (3 * MAX_TAP_DIVIDE) / 2;

  typedef enum logic [1:0] {
    IDLE,
    SHIFT,
    DELIVER
  } phase_type;

  typedef struct packed {
    logic       sel;
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } host_req_type;

  typedef struct packed {
    logic in;
    logic out;
    logic oe;
  } pin_type;

  // Half-period tick mask of the divider chain: period of 2, 4, 8 or 16 clocks
  function automatic logic [2:0] tap_mask(input logic [1:0] baud);
    case (baud)
      2'h0:    tap_mask = 3'h0;
      2'h1:    tap_mask = 3'h1;
      2'h2:    tap_mask = 3'h3;
      default: tap_mask = 3'h7;
    endcase
  endfunction

endpackage

// ==== logic/level_sync.sv ====
// Two-flop synchroniser for a group of level inputs
`timescale 1ns/10ps
module level_sync
  import serial_control_port_pkg::*;
#(
  parameter int WIDTH = 3
)
(
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] async_in,
  input  wire logic [WIDTH-1:0] reset_level,
  output logic      [WIDTH-1:0] sync_out
);

  if (WIDTH < 1)
  begin : g_bad_width
    $error("level_sync needs at least one bit");
  end

  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } sync_state_type;

  sync_state_type cur;
  sync_state_type next_cur;

  always_comb
  begin
    next_cur        = cur;
    next_cur.first  = async_in;
    next_cur.second = cur.first;
  end

  // Both stages start at the pins' idle level, so no false edge follows reset
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      cur <= '{first: reset_level, second: reset_level};
    end
    else if (clk_en)
    begin
      cur <= next_cur;
    end
  end

  assign sync_out = cur.second;

endmodule // level_sync

// ==== logic/word_buffer.sv ====
// Small FIFO with valid/ready on both sides
`timescale 1ns/10ps
module word_buffer
  import serial_control_port_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
)
(
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             clk_en,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
  begin : g_bad_shape
    $error("word_buffer depth must be a power of two, at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wp;
    logic [AW:0]                 rp;
  } buf_state_type;

  buf_state_type cur;
  buf_state_type next_cur;
  logic          full;
  logic          empty;

  assign full      = (cur.wp[AW] != cur.rp[AW]) && (cur.wp[AW-1:0] == cur.rp[AW-1:0]);
  assign empty     = (cur.wp == cur.rp);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = cur.mem[cur.rp[AW-1:0]];

  always_comb
  begin
    next_cur = cur;
    if (in_valid && !full)
    begin
      next_cur.mem[cur.wp[AW-1:0]] = in_data;
      next_cur.wp                  = cur.wp + {{AW{1'b0}}, 1'b1};
    end
    if (out_ready && !empty)
    begin
      next_cur.rp = cur.rp + {{AW{1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      cur <= '0;
    end
    else if (clk_en)
    begin
      cur <= next_cur;
    end
  end

endmodule // word_buffer

// ==== logic/serial_control_port.sv ====
// Byte-wide four-wire serial control port, master or slave
`timescale 1ns/10ps
module serial_control_port
  import serial_control_port_pkg::*;
#(
  parameter int BUFFER_DEPTH = 2
)
(
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic         clk_en,
  input  host_req_type      host_req,
  output logic [7:0]        host_rdata,
  output logic              exchange_done_interrupt,
  input  wire logic         select_line_0_in,
  output logic              select_line_0_out_n,
  output logic              select_line_0_oe,
  output logic              select_line_1_n,
  output logic              select_line_1_oe,
  input  wire logic         shift_clock_pin_in,
  output logic              shift_clock_pin_out,
  output logic              shift_clock_pin_oe,
  output logic              serial_out_pin,
  output logic              serial_out_pin_oe,
  input  wire logic         serial_in_pin,
  input  wire logic         modem_rts_n,
  output logic              rx_valid,
  input  wire logic         rx_ready,
  output logic [7:0]        rx_data
);

  if (BUFFER_DEPTH < 2)
  begin : g_bad_depth
    $error("serial_control_port needs a buffer of at least two words");
  end

  typedef struct packed {
    phase_type  phase;
    logic [7:0] shift;
    logic [7:0] control;
    logic [7:0] ch0_iface;
    logic [7:0] ch1_iface;
    logic [3:0] count;
    logic [2:0] prescale;
    logic       clk_level;
    logic       tx_bit;
    logic [7:0] rdata;
    logic       sel_prev;
    logic       clk_prev;
  } port_state_type;

  localparam port_state_type STATE_RESET = '{
    phase:     IDLE,
    shift:     DATA_RESET,
    control:   CONTROL_RESET,
    ch0_iface: IFACE_RESET,
    ch1_iface: IFACE_RESET,
    count:     4'h0,
    prescale:  3'h0,
    clk_level: 1'b0,
    tx_bit:    1'b0,
    rdata:     8'h00,
    sel_prev:  1'b1,
    clk_prev:  1'b0
  };

  port_state_type cur;
  port_state_type next_cur;

  logic [2:0] sync_in;
  logic [2:0] sync_out;
  logic       sel_sync;
  logic       clk_sync;
  logic       rx_sync;
  logic       push_valid;
  logic       push_ready;
  logic [7:0] push_data;

  logic       port_on;
  logic       slave_mode;
  logic       master_on;
  logic       slave_on;
  logic       idle_level;
  logic       tick;
  logic       slave_selected;
  logic       busy;
  logic [7:0] shifted;

  assign sync_in = {select_line_0_in, shift_clock_pin_in, serial_in_pin};

  // Slave-side pins pass two flops before any edge detection
  level_sync #(
    .WIDTH (3)
  ) u_level_sync (
    .mclk        (mclk),
    .rst         (rst),
    .clk_en      (clk_en),
    .async_in    (sync_in),
    .reset_level (3'h7),
    .sync_out    (sync_out)
  );

  assign sel_sync = sync_out[2];
  assign clk_sync = sync_out[1];
  assign rx_sync  = sync_out[0];

  word_buffer #(
    .WIDTH (8),
    .DEPTH (BUFFER_DEPTH)
  ) u_word_buffer (
    .mclk      (mclk),
    .rst       (rst),
    .clk_en    (clk_en),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (push_data),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_data)
  );

  assign port_on        = cur.ch0_iface[SERIAL_PORT_ENABLE_BIT_BIT];
  assign slave_mode     = cur.ch0_iface[SLAVE_BIT];
  assign master_on      = port_on && !slave_mode;
  assign slave_on       = port_on && slave_mode;
  assign idle_level     = cur.control[CI_BIT];
  assign tick           = (cur.prescale & tap_mask(cur.control[BAUD_MSB:BAUD_LSB])) ==
                          tap_mask(cur.control[BAUD_MSB:BAUD_LSB]);
  assign slave_selected = slave_on && !sel_sync;
  assign busy           = (cur.phase != IDLE) || slave_selected;

  always_comb
  begin
    next_cur   = cur;
    push_valid = 1'b0;
    shifted    = {cur.shift[6:0], serial_in_pin};
    push_data  = shifted;
    next_cur.prescale = cur.prescale + 3'h1;
    next_cur.sel_prev = sel_sync;
    next_cur.clk_prev = clk_sync;

    // Host writes
    if (host_req.sel && host_req.wr)
    begin
      case (host_req.addr)
        DATA_OFFSET:
        begin
          if (!busy)
          begin
            next_cur.shift = host_req.wdata;
          end
        end
        CONTROL_OFFSET:
        begin
          next_cur.control[ENABLE0_BIT]       = host_req.wdata[ENABLE0_BIT];
          next_cur.control[ENABLE1_BIT]       = host_req.wdata[ENABLE1_BIT];
          next_cur.control[DONE_IE_BIT]       = host_req.wdata[DONE_IE_BIT];
          next_cur.control[BAUD_MSB:BAUD_LSB] = host_req.wdata[BAUD_MSB:BAUD_LSB];
          next_cur.control[CI_BIT]            = host_req.wdata[CI_BIT];
          if (host_req.wdata[DONE_BIT])
          begin
            next_cur.control[DONE_BIT] = 1'b0;
          end
          if (cur.phase == IDLE && master_on && host_req.wdata[TRANSMIT_BIT])
          begin
            next_cur.control[TRANSMIT_BIT] = 1'b1;
          end
        end
        CH0_IFACE_OFFSET:
        begin
          next_cur.ch0_iface = host_req.wdata;
        end
        CH1_IFACE_OFFSET:
        begin
          next_cur.ch1_iface = host_req.wdata;
        end
        default:
        begin
          next_cur.ch0_iface = next_cur.ch0_iface;
        end
      endcase
    end

    // Host reads
    if (host_req.sel && host_req.rd)
    begin
      case (host_req.addr)
        DATA_OFFSET:      next_cur.rdata = busy ? BUSY_READ : cur.shift;
        CONTROL_OFFSET:   next_cur.rdata = cur.control;
        CH0_IFACE_OFFSET: next_cur.rdata = cur.ch0_iface;
        CH1_IFACE_OFFSET: next_cur.rdata = cur.ch1_iface;
        default:          next_cur.rdata = 8'h00;
      endcase
    end

    // Shift engine; hardware sets come last so they win over host clears
    case (cur.phase)
      IDLE:
      begin
        next_cur.clk_level = idle_level;
        if (master_on && cur.control[TRANSMIT_BIT] && push_ready && tick)
        begin
          next_cur.phase     = SHIFT;
          next_cur.count     = 4'h0;
          next_cur.clk_level = !idle_level;
          next_cur.tx_bit    = cur.shift[7];
        end
        else if (slave_selected)
        begin
          if (cur.clk_prev == idle_level && clk_sync != idle_level)
          begin
            next_cur.tx_bit = cur.shift[7];
          end
          else if (cur.clk_prev != idle_level && clk_sync == idle_level)
          begin
            next_cur.shift = {cur.shift[6:0], rx_sync};
          end
        end
        else if (slave_on && sel_sync && !cur.sel_prev)
        begin
          if (push_ready)
          begin
            push_valid                 = 1'b1;
            push_data                  = cur.shift;
            next_cur.control[DONE_BIT] = 1'b1;
          end
          else
          begin
            next_cur.phase = DELIVER;
          end
        end
      end
      SHIFT:
      begin
        if (!master_on)
        begin
          next_cur.phase                 = IDLE;
          next_cur.control[TRANSMIT_BIT] = 1'b0;
          next_cur.clk_level             = idle_level;
        end
        else if (tick)
        begin
          if (cur.clk_level != idle_level)
          begin
            next_cur.clk_level = idle_level;
            next_cur.shift     = shifted;
            next_cur.count     = cur.count + 4'h1;
            if (cur.count == BITS_PER_BURST - 4'h1)
            begin
              next_cur.phase                 = IDLE;
              next_cur.control[TRANSMIT_BIT] = 1'b0;
              next_cur.control[DONE_BIT]     = 1'b1;
              push_valid                     = 1'b1;
            end
          end
          else
          begin
            next_cur.clk_level = !idle_level;
            next_cur.tx_bit    = cur.shift[7];
          end
        end
      end
      DELIVER:
      begin
        push_data = cur.shift;
        if (push_ready)
        begin
          push_valid                 = 1'b1;
          next_cur.phase             = IDLE;
          next_cur.control[DONE_BIT] = 1'b1;
        end
      end
      default:
      begin
        next_cur.phase = IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      cur <= STATE_RESET;
    end
    else if (clk_en)
    begin
      cur <= next_cur;
    end
  end

  assign host_rdata              = cur.rdata;
  assign exchange_done_interrupt = cur.control[DONE_BIT] && cur.control[DONE_IE_BIT];
  assign select_line_0_out_n     = !cur.control[ENABLE0_BIT];
  assign select_line_0_oe        = master_on;
  assign select_line_1_n         = !cur.control[ENABLE1_BIT];
  assign select_line_1_oe        = cur.ch1_iface[SERIAL_PORT_ENABLE_BIT_BIT];
  assign shift_clock_pin_out     = cur.clk_level;
  assign shift_clock_pin_oe      = master_on;
  assign serial_out_pin          = port_on ? cur.tx_bit : modem_rts_n;
  assign serial_out_pin_oe       = 1'b1;

endmodule // serial_control_port

// ==== verif/serial_control_port_props.sv ====
// Concurrent checks on the serial control port's pins and host bus
`timescale 1ns/10ps
module serial_control_port_props
  import serial_control_port_pkg::*;
(
  input wire logic       mclk,
  input wire logic       rst,
  input host_req_type    host_req,
  input wire logic [7:0] host_rdata,
  input wire logic       exchange_done_interrupt,
  input wire logic       select_line_0_in,
  input wire logic       select_line_0_out_n,
  input wire logic       select_line_0_oe,
  input wire logic       shift_clock_pin_out,
  input wire logic       shift_clock_pin_oe,
  input wire logic       rx_valid
);
  logic       ci_q, ie_q, clk_d;
  logic [1:0] ch0_q;
  logic [7:0] toggles;
  wire        ctl_wr = host_req.sel && host_req.wr && host_req.addr == CONTROL_OFFSET;

  // Shadow of the mode bits and a count of master clock changes per burst
  always_ff @(posedge mclk)
  begin
    clk_d <= shift_clock_pin_out;
    if (rst)
    begin
      ci_q <= 1'h0;
      ie_q <= 1'h0;
      ch0_q <= 2'h0;
      toggles <= 8'h00;
    end
    else
    begin
      if (ctl_wr)
      begin
        ci_q <= host_req.wdata[CI_BIT];
        ie_q <= host_req.wdata[DONE_IE_BIT];
      end
      if (host_req.sel && host_req.wr && host_req.addr == CH0_IFACE_OFFSET)
        ch0_q <= host_req.wdata[1:0];
      if (ctl_wr && host_req.wdata[TRANSMIT_BIT])
        toggles <= 8'h00;
      else if (shift_clock_pin_oe && shift_clock_pin_out != clk_d)
        toggles <= toggles + 8'h01;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  sequence s_tx_go;
    ctl_wr && host_req.wdata[TRANSMIT_BIT] && shift_clock_pin_oe && !rx_valid && (toggles == 8'h00 || toggles == 8'h10);
  endsequence
  sequence s_burst_end;
    $rose(exchange_done_interrupt) && shift_clock_pin_oe;
  endsequence

  a_sel0_follow: assert property (ctl_wr |=> select_line_0_out_n == !$past(host_req.wdata[ENABLE0_BIT]))
    else $error("select 0 does not follow its bit");
  a_sel_idle: assert property ($fell(select_line_0_out_n) && shift_clock_pin_oe |-> shift_clock_pin_out == ci_q)
    else $error("select fell with clock not idle");
  a_burst_pulses: assert property (s_burst_end |=> toggles == 8'h10)
    else $error("burst did not have eight pulses");
  a_start_bound: assert property (s_tx_go |-> ##[1:24] shift_clock_pin_out != ci_q)
    else $error("burst start too late");
  a_busy_read: assert property (host_req.sel && host_req.rd && host_req.addr == DATA_OFFSET && shift_clock_pin_oe
      && toggles inside {[8'h01:8'h0E]} |=> host_rdata == BUSY_READ)
    else $error("busy data read not zero");
  a_irq_gate: assert property (!ie_q && !$past(ie_q) |-> !exchange_done_interrupt)
    else $error("interrupt while disabled");
  a_slave_done: assert property (ch0_q == 2'h3 && ie_q && $rose(select_line_0_in) |-> ##[1:6] exchange_done_interrupt)
    else $error("slave select rise gave no interrupt");
  a_master_pins: assert property (ch0_q == 2'h1 && $past(ch0_q) == 2'h1 |-> select_line_0_oe && shift_clock_pin_oe)
    else $error("master pins not driven");
  a_slave_pins: assert property (ch0_q == 2'h3 && $past(ch0_q) == 2'h3 |-> !select_line_0_oe && !shift_clock_pin_oe)
    else $error("slave pins still driven");
endmodule // serial_control_port_props

bind serial_control_port serial_control_port_props i_serial_control_port_props (.mclk, .rst, .host_req, .host_rdata,
  .exchange_done_interrupt, .select_line_0_in, .select_line_0_out_n, .select_line_0_oe, .shift_clock_pin_out,
  .shift_clock_pin_oe, .rx_valid);

// ==== verif/peripheral_model.sv ====
// Behavioural serial peripheral answering master bursts
`timescale 1ns/10ps
module peripheral_model
(
  input  wire logic       sclk,
  input  wire logic       sel_n,
  input  wire logic       ci,
  input  wire logic       mosi,
  input  wire logic [7:0] reply,
  output logic            miso,
  output logic      [7:0] got
);
  logic [7:0] sh;
  initial
  begin
    miso = 1'h1;
    got = 8'h00;
    sh = 8'h00;
  end
  always @(negedge sel_n)
  begin
    sh = reply;
    got = 8'h00;
  end
  // Released line shows the inverse of its last bit
  always @(posedge sel_n)
    miso = ~miso;
  always @(sclk)
    if (!sel_n)
    begin
      if (sclk != ci)
      begin
        miso = sh[7];
        sh = {sh[6:0], 1'h0};
      end
      else
        got = {got[6:0], mosi};
    end
endmodule // peripheral_model

// ==== verif/serial_control_port_tb_top.sv ====
// Self-checking bench for the serial control port
`timescale 1ns/10ps
module serial_control_port_tb_top import serial_control_port_pkg::*;;
  logic         mclk, rst, clk_en, select_line_0_in, shift_clock_pin_in, tb_sin, modem_rts_n, rx_ready, cur_ci;
  logic         exchange_done_interrupt, select_line_0_out_n, select_line_0_oe, select_line_1_n, select_line_1_oe;
  logic         shift_clock_pin_out, shift_clock_pin_oe, serial_out_pin, serial_out_pin_oe, rx_valid, miso;
  logic [7:0]   host_rdata, rx_data, reply, got;
  host_req_type host_req;
  int           mismatches, checks_done;
  logic [7:0]   q[$];
  wire          serial_in_pin = shift_clock_pin_oe ? miso : tb_sin;

  serial_control_port i_serial_control_port (.mclk, .rst, .clk_en, .host_req, .host_rdata, .exchange_done_interrupt,
    .select_line_0_in, .select_line_0_out_n, .select_line_0_oe, .select_line_1_n, .select_line_1_oe,
    .shift_clock_pin_in, .shift_clock_pin_out, .shift_clock_pin_oe, .serial_out_pin, .serial_out_pin_oe,
    .serial_in_pin, .modem_rts_n, .rx_valid, .rx_ready, .rx_data);
  peripheral_model i_peripheral_model (.sclk(shift_clock_pin_out), .sel_n(select_line_0_out_n), .ci(cur_ci),
    .mosi(serial_out_pin), .reply, .miso, .got);

  always #2 mclk = ~mclk;

  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e)
    begin
      mismatches++;
      $display("ERROR at %0t: got %h, expected %h", $time, g, e);
    end
  endtask
  task automatic wait_until(input logic clk_start);
    int n;
    for (n = 0; n < 300; n++)
    begin
      @(negedge mclk);
      if (clk_start ? shift_clock_pin_out !== cur_ci : exchange_done_interrupt === 1'h1)
        break;
    end
    if (n == 300)
    begin
      mismatches++;
      $display("ERROR at %0t: wait timed out", $time);
      give_verdict();
    end
  endtask
  task automatic host_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    host_req <= '{1'h1, 1'h1, 1'h0, a, d};
    @(posedge mclk);
    host_req <= '0;
  endtask
  task automatic host_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    host_req <= '{1'h1, 1'h0, 1'h1, a, 8'h00};
    @(posedge mclk);
    host_req <= '0;
    @(negedge mclk);
    d = host_rdata;
  endtask
  task automatic t_drain;
    logic [7:0] e;
    e = q.pop_front();
    @(negedge mclk);
    chk({7'h00, rx_valid}, 8'h01);
    chk(rx_data, e);
    @(posedge mclk);
    rx_ready <= 1'h1;
    @(posedge mclk);
    rx_ready <= 1'h0;
  endtask
  task automatic t_regs;
    logic [7:0] d;
    host_rd(CONTROL_OFFSET, d);
    chk(d, CONTROL_RESET);
    host_rd(CH1_IFACE_OFFSET, d);
    chk(d, IFACE_RESET);
    host_rd(8'h7F, d);
    chk(d, 8'h00);
    @(posedge mclk);
    modem_rts_n <= 1'h0;
    repeat (2) @(negedge mclk);
    chk({7'h00, serial_out_pin}, 8'h00);
    chk({7'h00, serial_out_pin_oe}, 8'h01);
    host_wr(CH1_IFACE_OFFSET, 8'hA5);
    host_rd(CH1_IFACE_OFFSET, d);
    chk(d, 8'hA5);
    chk({7'h00, select_line_1_oe}, 8'h01);
    host_wr(CONTROL_OFFSET, 8'h02);
    @(negedge mclk);
    chk({7'h00, select_line_1_n}, 8'h00);
    host_wr(CONTROL_OFFSET, 8'h00);
  endtask
  task automatic t_master(input logic ci, input logic [1:0] baud, input logic [7:0] tx, input logic stall);
    logic [7:0] d;
    int         n;
    cur_ci = ci;
    reply = tx ^ 8'h5A;
    host_wr(CH0_IFACE_OFFSET, 8'h01);
    host_wr(CONTROL_OFFSET, {ci, baud, 5'h10});
    host_wr(CONTROL_OFFSET, {ci, baud, 5'h11});
    @(negedge mclk);
    chk({7'h00, select_line_0_out_n}, 8'h00);
    host_wr(DATA_OFFSET, tx);
    host_wr(CONTROL_OFFSET, {ci, baud, 5'h15});
    if (stall)
    begin
      repeat (40) @(negedge mclk);
      chk({7'h00, shift_clock_pin_out}, {7'h00, ci});
      t_drain();
    end
    wait_until(1'h1);
    // Half period of the shift clock in mclk cycles
    n = 0;
    while (shift_clock_pin_out !== ci && n < 40)
    begin
      @(negedge mclk);
      n++;
    end
    chk(n[7:0], 8'h01 << baud);
    if (n == 40)
      give_verdict();
    host_wr(DATA_OFFSET, 8'hFF);
    host_rd(DATA_OFFSET, d);
    chk(d, BUSY_READ);
    host_rd(CONTROL_OFFSET, d);
    chk(d & 8'h04, 8'h04);
    wait_until(1'h0);
    repeat (24) @(posedge mclk);
    host_rd(CONTROL_OFFSET, d);
    chk(d & 8'h0C, 8'h08);
    host_rd(DATA_OFFSET, d);
    chk(d, reply);
    chk(got, tx);
    q.push_back(reply);
    host_wr(CONTROL_OFFSET, {ci, baud, 5'h01});
    @(negedge mclk);
    chk({7'h00, exchange_done_interrupt}, 8'h00);
    host_wr(CONTROL_OFFSET, {ci, baud, 5'h18});
    @(negedge mclk);
    chk({7'h00, exchange_done_interrupt}, 8'h00);
  endtask
  task automatic t_pulse(input logic ci, input logic b, output logic o);
    @(posedge mclk);
    shift_clock_pin_in <= ~ci;
    tb_sin <= b;
    repeat (5) @(posedge mclk);
    o = serial_out_pin;
    shift_clock_pin_in <= ci;
    repeat (4) @(posedge mclk);
  endtask
  task automatic t_slave(input logic ci, input int n, input logic [7:0] tx, input logic [7:0] pat);
    logic [7:0] sh;
    logic [7:0] d;
    logic       o;
    @(posedge mclk);
    shift_clock_pin_in <= ci;
    host_wr(CH0_IFACE_OFFSET, 8'h03);
    host_wr(CONTROL_OFFSET, {ci, 2'h0, 5'h10});
    host_wr(DATA_OFFSET, tx);
    sh = tx;
    t_pulse(ci, 1'h1, o);
    @(posedge mclk);
    select_line_0_in <= 1'h0;
    for (int k = 0; k < n; k++)
    begin
      t_pulse(ci, pat[7 - k % 8], o);
      chk({7'h00, o}, {7'h00, sh[7]});
      sh = {sh[6:0], pat[7 - k % 8]};
    end
    repeat (4) @(posedge mclk);
    select_line_0_in <= 1'h1;
    wait_until(1'h0);
    host_rd(DATA_OFFSET, d);
    chk(d, sh);
    host_wr(CONTROL_OFFSET, {ci, 2'h0, 5'h18});
  endtask

  initial
  begin
    mclk = 1'h0;
    rst = 1'h1;
    clk_en = 1'h1;
    host_req = '0;
    select_line_0_in = 1'h1;
    shift_clock_pin_in = 1'h0;
    tb_sin = 1'h0;
    modem_rts_n = 1'h1;
    rx_ready = 1'h0;
    cur_ci = 1'h0;
    reply = 8'h00;
    mismatches = 0;
    checks_done = 0;
    repeat (3) @(posedge mclk);
    rst <= 1'h0;
    t_regs();
    for (int i = 0; i < 4; i++)
    begin
      t_master(i[0], i[1:0], 8'hA3 ^ i[7:0], i == 2);
      if (i >= 2)
        while (q.size() != 0)
          t_drain();
    end
    @(posedge mclk);
    rx_ready <= 1'h1;
    t_slave(1'h0, 8, 8'h96, 8'hC5);
    t_slave(1'h1, 3, 8'h3C, 8'hA0);
    t_slave(1'h0, 10, 8'h81, 8'h5E);
    give_verdict();
  end
endmodule // serial_control_port_tb_top
